// file: logic/bmf_pkg.sv
`default_nettype none
// ****************************************************************
// register map and field layout
// ****************************************************************
package bmf_pkg;
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 32;
    localparam int          LIMIT_W           = 8;
    localparam logic [7:0]  OFS_CHAN_HI       = 8'hb4;
    localparam logic [7:0]  OFS_CHAN_LO       = 8'hb8;
    localparam logic [7:0]  OFS_FAIR_CTRL     = 8'hdc;
    localparam logic [7:0]  OFS_STATUS        = 8'he8;
    localparam logic [31:0] CHAN_RESET_VAL    = 32'hffffffff;
    localparam logic [7:0]  LIMIT_RESET_VAL   = 8'h00;
    localparam logic [31:0] ZERO_WORD         = 32'h00000000;
    localparam logic [7:0]  ZERO_COUNT        = 8'h00;
    localparam logic [7:0]  ONE_COUNT         = 8'h01;
    // status word layout
    localparam int          ST_COUNT_LSB      = 0;
    localparam int          ST_EXHAUST_BIT    = 8;
endpackage
`default_nettype wire

// file: logic/bmf_regs.sv
`timescale 1ns/1ns
`default_nettype none
module bmf_regs #(
    parameter int LIMIT_W = bmf_pkg::LIMIT_W
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [bmf_pkg::ADDR_W-1:0] paddr,
    input  wire logic [bmf_pkg::DATA_W-1:0] pwdata,
    output logic      [bmf_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       soft_reset,
    input  wire logic                       global_reset,
    input  wire logic                       host_bus_reset,
    input  wire logic                       bus_reset,
    output logic      [bmf_pkg::DATA_W-1:0] csr_chan_avail_hi,
    output logic      [bmf_pkg::DATA_W-1:0] csr_chan_avail_lo,
    input  wire logic                       fairness_start,
    input  wire logic                       pri_req_want,
    output logic                            pri_req_grant
);
    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic               wr_en;
    logic               load_csr;
    logic [31:0]        mask_hi_reg;
    logic [31:0]        mask_lo_reg;
    logic [LIMIT_W-1:0] limit_reg;
    logic [LIMIT_W-1:0] used_reg;
    logic [LIMIT_W-1:0] used_next;
    logic               exhausted;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // zero wait states: every access ends in its first access cycle
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign pslverr = psel && penable &&
                     !(hit(paddr, bmf_pkg::OFS_CHAN_HI) ||
                       hit(paddr, bmf_pkg::OFS_CHAN_LO) ||
                       hit(paddr, bmf_pkg::OFS_FAIR_CTRL) ||
                       (hit(paddr, bmf_pkg::OFS_STATUS) && !pwrite));

    // ****************************************************************
    // channel mask registers
    // ****************************************************************
    // all ones on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_hi_reg <= bmf_pkg::CHAN_RESET_VAL;
            mask_lo_reg <= bmf_pkg::CHAN_RESET_VAL;
        end else if (soft_reset) begin
            mask_hi_reg <= bmf_pkg::CHAN_RESET_VAL;
            mask_lo_reg <= bmf_pkg::CHAN_RESET_VAL;
        end else if (wr_en) begin
            // bus reset not a term here, so masks survive it
            if (hit(paddr, bmf_pkg::OFS_CHAN_HI)) begin
                mask_hi_reg <= pwdata;
            end
            if (hit(paddr, bmf_pkg::OFS_CHAN_LO)) begin
                mask_lo_reg <= pwdata;
            end
        end
    end

    // ****************************************************************
    // bus management csr load
    // ****************************************************************
    assign load_csr = global_reset || host_bus_reset || bus_reset;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csr_chan_avail_hi <= bmf_pkg::CHAN_RESET_VAL;
            csr_chan_avail_lo <= bmf_pkg::CHAN_RESET_VAL;
        end else if (load_csr) begin
            csr_chan_avail_hi <= mask_hi_reg;
            csr_chan_avail_lo <= mask_lo_reg;
        end
    end

    // ****************************************************************
    // fairness limit
    // ****************************************************************
    // limit resets to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_reg <= bmf_pkg::LIMIT_RESET_VAL;
        end else if (soft_reset) begin
            limit_reg <= bmf_pkg::LIMIT_RESET_VAL;
        end else if (wr_en && hit(paddr, bmf_pkg::OFS_FAIR_CTRL)) begin
            limit_reg <= pwdata[LIMIT_W-1:0];
        end
    end

    assign exhausted     = used_reg >= limit_reg;
    assign pri_req_grant = pri_req_want && !exhausted && !fairness_start;

    // counter restarts each interval; grants blocked in that cycle
    always_comb begin
        used_next = used_reg;
        if (fairness_start) begin
            used_next = bmf_pkg::ZERO_COUNT;
        end else if (pri_req_grant) begin
            used_next = used_reg + bmf_pkg::ONE_COUNT;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            used_reg <= bmf_pkg::ZERO_COUNT;
        end else if (soft_reset) begin
            used_reg <= bmf_pkg::ZERO_COUNT;
        end else begin
            used_reg <= used_next;
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    // upper bits of fairness word read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= bmf_pkg::ZERO_WORD;
        end else if (psel && !penable && !pwrite) begin
            prdata <= bmf_pkg::ZERO_WORD;
            if (hit(paddr, bmf_pkg::OFS_CHAN_HI)) begin
                prdata <= mask_hi_reg;
            end
            if (hit(paddr, bmf_pkg::OFS_CHAN_LO)) begin
                prdata <= mask_lo_reg;
            end
            if (hit(paddr, bmf_pkg::OFS_FAIR_CTRL)) begin
                prdata[LIMIT_W-1:0] <= limit_reg;
            end
            if (hit(paddr, bmf_pkg::OFS_STATUS)) begin
                prdata[bmf_pkg::ST_COUNT_LSB +: LIMIT_W] <= used_reg;
                prdata[bmf_pkg::ST_EXHAUST_BIT] <= exhausted;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_mask_soft_reset: assert property (
        @(posedge pclk) disable iff (!presetn)
        soft_reset |=> mask_hi_reg == bmf_pkg::CHAN_RESET_VAL &&
                       mask_lo_reg == bmf_pkg::CHAN_RESET_VAL)
        else $error("masks not all ones after soft reset");

    a_mask_bus_keep: assert property (
        @(posedge pclk) disable iff (!presetn)
        bus_reset && !soft_reset && !wr_en |=> $stable(mask_hi_reg) &&
                                              $stable(mask_lo_reg))
        else $error("bus reset changed a mask");

    a_csr_hi_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        load_csr |=> csr_chan_avail_hi == $past(mask_hi_reg))
        else $error("high csr not loaded");

    a_csr_lo_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        load_csr |=> csr_chan_avail_lo == $past(mask_lo_reg))
        else $error("low csr not loaded");

    a_mask_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && !soft_reset && hit(paddr, bmf_pkg::OFS_CHAN_LO)
        |=> mask_lo_reg == $past(pwdata))
        else $error("low mask write lost");

    a_grant_limit: assert property (
        @(posedge pclk) disable iff (!presetn)
        pri_req_grant |-> used_reg < limit_reg)
        else $error("grant beyond limit");

    a_fair_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit(paddr, bmf_pkg::OFS_FAIR_CTRL)
        |=> prdata[31:LIMIT_W] == '0 &&
            prdata[LIMIT_W-1:0] == $past(limit_reg))
        else $error("fairness read wrong");

    a_limit_reset: assert property (
        @(posedge pclk) disable iff (!presetn)
        soft_reset |=> limit_reg == bmf_pkg::LIMIT_RESET_VAL && used_reg == '0)
        else $error("limit not zero after soft reset");

    // ****************************************************************
    // bus and counter assertions
    // ****************************************************************
    // read setup cycle: prdata is loaded here and stands through access
    sequence s_read_setup;
        psel && !penable && !pwrite;
    endsequence

    // access cycle: the single edge at which a transfer completes
    sequence s_access;
        psel && penable;
    endsequence

    a_ready_high: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready)
        else $error("slave inserted a wait state");

    a_mask_hi_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && !soft_reset && hit(paddr, bmf_pkg::OFS_CHAN_HI)
        |=> mask_hi_reg == $past(pwdata))
        else $error("high mask write lost");

    a_hi_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_read_setup ##0 hit(paddr, bmf_pkg::OFS_CHAN_HI)
        |=> prdata == $past(mask_hi_reg))
        else $error("high mask read wrong");

    a_lo_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_read_setup ##0 hit(paddr, bmf_pkg::OFS_CHAN_LO)
        |=> prdata == $past(mask_lo_reg))
        else $error("low mask read wrong");

    a_read_stable: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_access |=> $stable(prdata))
        else $error("read data moved during access");

    a_err_no_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_access ##0 pslverr && !soft_reset
        |=> $stable(mask_hi_reg) && $stable(mask_lo_reg) &&
            $stable(limit_reg))
        else $error("refused write changed a register");

    a_mask_idle_keep: assert property (
        @(posedge pclk) disable iff (!presetn)
        !wr_en && !soft_reset
        |=> $stable(mask_hi_reg) && $stable(mask_lo_reg))
        else $error("mask changed without a write");

    a_csr_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !load_csr
        |=> $stable(csr_chan_avail_hi) && $stable(csr_chan_avail_lo))
        else $error("csr changed without a reset event");

    a_grant_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        fairness_start |-> !pri_req_grant)
        else $error("grant in interval start cycle");

    a_grant_want: assert property (
        @(posedge pclk) disable iff (!presetn)
        pri_req_grant |-> pri_req_want)
        else $error("grant without a request");

    a_limit_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        limit_reg == '0 |-> !pri_req_grant)
        else $error("grant with zero limit");

    a_count_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        fairness_start |=> used_reg == '0)
        else $error("count not cleared at interval start");

    a_count_step: assert property (
        @(posedge pclk) disable iff (!presetn)
        pri_req_grant && !soft_reset
        |=> used_reg == $past(used_reg) + bmf_pkg::ONE_COUNT)
        else $error("grant not counted");

    a_status_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_read_setup ##0 hit(paddr, bmf_pkg::OFS_STATUS)
        |=> prdata[bmf_pkg::ST_EXHAUST_BIT] == $past(exhausted))
        else $error("status limit flag wrong");

    a_limit_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && !soft_reset && hit(paddr, bmf_pkg::OFS_FAIR_CTRL)
        |=> limit_reg == $past(pwdata[LIMIT_W-1:0]))
        else $error("limit write lost");
endmodule
`default_nettype wire

// file: verif/bmf_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module bmf_regs_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        soft_reset = 1'b0;
    logic [2:0]  ev = 3'h0;
    logic [31:0] csr_hi;
    logic [31:0] csr_lo;
    logic        fstart = 1'b0;
    logic        want = 1'b0;
    logic        grant;
    logic [31:0] rd;
    logic        err;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          m_hi;
    int          m_lo;

    // ****************************************************************
    // clock and device
    // ****************************************************************
    always #50 pclk = ~pclk;
    bmf_regs bmf_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .soft_reset(soft_reset), .global_reset(ev[0]),
        .host_bus_reset(ev[1]), .bus_reset(ev[2]),
        .csr_chan_avail_hi(csr_hi), .csr_chan_avail_lo(csr_lo),
        .fairness_start(fstart), .pri_req_want(want),
        .pri_req_grant(grant));

    // ****************************************************************
    // checking and bus tasks
    // ****************************************************************
    task automatic complete_run();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; the wait for pready is bounded
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            complete_run();
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input logic e_err);
        apb(1'b0, a, 32'h00000000);
        chk(rd, e);
        chk({31'h0, err}, {31'h0, e_err});
    endtask
    // grants in one fresh interval must stop at the limit
    task automatic fair(input int lim);
        int n;
        apb(1'b1, bmf_pkg::OFS_FAIR_CTRL, lim);
        fstart <= 1'b1;
        @(posedge pclk);
        fstart <= 1'b0;
        want <= 1'b1;
        n = 0;
        repeat (12) begin
            @(posedge pclk);
            if (grant === 1'b1) n++;
        end
        want <= 1'b0;
        chk(n, lim);
        rdchk(bmf_pkg::OFS_STATUS, 32'h00000100 | lim, 1'b0);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'hde75));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(bmf_pkg::OFS_CHAN_HI, 32'hffffffff, 1'b0);
        rdchk(bmf_pkg::OFS_CHAN_LO, 32'hffffffff, 1'b0);
        rdchk(bmf_pkg::OFS_FAIR_CTRL, 32'h00000000, 1'b0);
        chk(csr_hi, 32'hffffffff);
        chk(csr_lo, 32'hffffffff);
        rdchk(8'h40, 32'h00000000, 1'b1);
        // status word is read only: a write is refused
        apb(1'b1, bmf_pkg::OFS_STATUS, 32'h00000000);
        chk({31'h0, err}, 32'h00000001);
        // each reset event copies fresh random masks out
        for (int i = 0; i < 3; i++) begin
            m_hi = $urandom();
            m_lo = $urandom();
            apb(1'b1, bmf_pkg::OFS_CHAN_HI, m_hi);
            apb(1'b1, bmf_pkg::OFS_CHAN_LO, m_lo);
            rdchk(bmf_pkg::OFS_CHAN_HI, m_hi, 1'b0);
            rdchk(bmf_pkg::OFS_CHAN_LO, m_lo, 1'b0);
            ev[i] <= 1'b1;
            @(posedge pclk);
            ev[i] <= 1'b0;
            @(posedge pclk);
            #1;
            chk(csr_hi, m_hi);
            chk(csr_lo, m_lo);
        end
        rdchk(bmf_pkg::OFS_CHAN_HI, m_hi, 1'b0);
        rdchk(bmf_pkg::OFS_CHAN_LO, m_lo, 1'b0);
        apb(1'b1, bmf_pkg::OFS_FAIR_CTRL, 32'hffffffff);
        rdchk(bmf_pkg::OFS_FAIR_CTRL, 32'h000000ff, 1'b0);
        fair(0);
        fair($urandom_range(1, 8));
        fair($urandom_range(1, 8));
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        rdchk(bmf_pkg::OFS_CHAN_HI, 32'hffffffff, 1'b0);
        rdchk(bmf_pkg::OFS_CHAN_LO, 32'hffffffff, 1'b0);
        rdchk(bmf_pkg::OFS_FAIR_CTRL, 32'h00000000, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
